// File: bhp_host_model.sv
`default_nettype none
// ----------------------------------------------------------------------
// host processor side of the wake handshake
// ----------------------------------------------------------------------
module bhp_host_model (
    input  wire logic want_wake,            // host wants the radio
    input  wire logic dev_pol_hi,           // host view of device wake polarity
    input  wire logic host_pol_hi,          // host view of host wake polarity
    input  wire logic host_wake_from_radio, // pin from the radio
    output logic      radio_wake_from_host, // push-pull, never released
    output logic      host_awake            // host serves the radio
);
    timeunit 1ns;
    timeprecision 1ps;
    // pad mux assumed set to the handshake function by software
    // wake driven to its active level before any traffic
    assign radio_wake_from_host = want_wake ~^ dev_pol_hi;
    // awake while host wake asserted, free to sleep otherwise
    assign host_awake = host_wake_from_radio ~^ host_pol_hi;
endmodule // bhp_host_model
`default_nettype wire

// File: bhp_map.vh
`ifndef BHP_MAP_VH
`define BHP_MAP_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define BHP_OFF_CTRL      8'h00
`define BHP_OFF_PWRDN     8'h04
`define BHP_OFF_STATUS    8'h08
`define BHP_OFF_EVENT     8'h0C

// ----------------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------------
`define BHP_CTRL_HS_EN    0
`define BHP_CTRL_UART     1
`define BHP_CTRL_WIN_POL  2
`define BHP_CTRL_HWK_POL  3
`define BHP_CTRL_SLP_OK   4
`define BHP_CTRL_ATTN     5
`define BHP_CTRL_CLK_REQ  6
`define BHP_CTRL_RST      8'h0C

// ----------------------------------------------------------------------
// power-down register: bits 0..3 force tx, rx, pll, pa off; bit 4 auto
// ----------------------------------------------------------------------
`define BHP_PD_TX         0
`define BHP_PD_RX         1
`define BHP_PD_PLL        2
`define BHP_PD_PA         3
`define BHP_PD_AUTO       4
`define BHP_PWRDN_RST     8'h10

// ----------------------------------------------------------------------
// status and event fields
// ----------------------------------------------------------------------
`define BHP_ST_AWAKE      0
`define BHP_ST_WAKE_IN    1
`define BHP_ST_HWAKE      2
`define BHP_ST_CLKREQ     3
`define BHP_ST_PD_LSB     4
`define BHP_EV_PEND       0

// ----------------------------------------------------------------------
// bus response codes and state codes
// ----------------------------------------------------------------------
`define BHP_RESP_OKAY     2'h0
`define BHP_RESP_SLVERR   2'h2
`define BHP_ST_RUN        1'h0
`define BHP_ST_SLEEP      1'h1

`endif

// File: bhp_power_handshake.v
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`include "bhp_map.vh"
`default_nettype none
// Functional notes
// - wake asserted: leave sleep, stay awake
// - wake deasserted: sleep only when criteria met
// - raise host wake when host work pending
// - both wake lines have software polarity
// - clock request high when radio or wlan needs clock
// - clock request low during power-up and reset
// - wake handshake only in uart mode when enabled
// - separate tx, rx, pll, pa power-downs
// - power saving by software or packet handling
// - packet handling powers rf sections on demand

module bhp_power_handshake #(
    parameter AW = 8
) (
    input  wire          aclk,
    input  wire          aresetn,
    // axi4-lite slave
    input  wire [AW-1:0] s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output wire          s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output wire          s_axi_wready,
    output wire [1:0]    s_axi_bresp,
    output wire          s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [AW-1:0] s_axi_araddr,
    input  wire          s_axi_arvalid,
    output wire          s_axi_arready,
    output wire [31:0]   s_axi_rdata,
    output wire [1:0]    s_axi_rresp,
    output wire          s_axi_rvalid,
    input  wire          s_axi_rready,
    // handshake pins
    input  wire          radio_wake_from_host,
    output wire          host_wake_from_radio,
    output wire          clk_req,
    // baseband core side
    input  wire          baseband_idle,
    input  wire          baseband_host_event,
    input  wire          baseband_tx_active,
    input  wire          baseband_rx_active,
    input  wire          wlan_clk_need,
    output wire          pd_tx,
    output wire          pd_rx,
    output wire          pd_pll,
    output wire          pd_pa,
    output wire          radio_asleep
);
    // ------------------------------------------------------------------
    // address decode shared by the read and write paths
    // ------------------------------------------------------------------
    // returns {hit, index}
    function [2:0] bhp_dec;
        input [AW-1:0] a;
        begin
            case (a[7:0])
                `BHP_OFF_CTRL:   bhp_dec = 3'h4;
                `BHP_OFF_PWRDN:  bhp_dec = 3'h5;
                `BHP_OFF_STATUS: bhp_dec = 3'h6;
                `BHP_OFF_EVENT:  bhp_dec = 3'h7;
                default:         bhp_dec = 3'h0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    reg [7:0]    ctrl_ff;        // handshake configuration
    reg [7:0]    pwrdn_ff;       // software power-down and auto enable
    reg          evt_ff;         // sticky host-pending event
    reg          aw_full_ff;     // write address held
    reg [AW-1:0] aw_addr_ff;     // held write address
    reg          w_full_ff;      // write data held
    reg [31:0]   w_data_ff;      // held write data
    reg          w_lane0_ff;     // byte lane 0 enabled
    reg          bvalid_ff;      // write response pending
    reg [1:0]    bresp_ff;       // write response code
    reg          rvalid_ff;      // read data pending
    reg [1:0]    rresp_ff;       // read response code
    reg [31:0]   rdata_ff;       // read data
    reg          state_ff;       // run or sleep
    reg          nxt_state;      // next sleep state
    reg          hwake_ff;       // host wake asserted, before pin polarity
    reg          clk_req_ff;     // clock request pin level
    reg [3:0]    pd_ff;          // pa, pll, rx, tx power-downs
    reg [3:0]    nxt_pd;         // next power-down set

    wire         wake_raw;       // device wake after synchroniser
    wire         wake_act;       // device wake, active after polarity
    wire         hs_on;          // handshake lines in use
    wire         sleep_crit;     // own sleep criteria met
    wire         host_need;      // host attention wanted
    wire         do_write;       // address and data both held
    wire [2:0]   wdec;           // decoded write address
    wire [2:0]   rdec;           // decoded read address
    wire         ev_clr;         // write-one-to-clear on event bit
    wire [31:0]  status_word;    // live status image
    reg  [31:0]  rd_mux;         // read data selection

    // ------------------------------------------------------------------
    // wake input crossing
    // ------------------------------------------------------------------
    // polarity is applied after both flops so no gate sees the first
    bhp_sync #(
        .WIDTH (1)
    ) u_wake_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (radio_wake_from_host),
        .sync_out (wake_raw)
    );
    assign wake_act = ~(wake_raw ^ ctrl_ff[`BHP_CTRL_WIN_POL]);

    // pins only carry the handshake in uart mode and when enabled
    assign hs_on = ctrl_ff[`BHP_CTRL_HS_EN] & ctrl_ff[`BHP_CTRL_UART];

    // criteria: software permits sleep, baseband idle, nothing for host
    assign sleep_crit = ctrl_ff[`BHP_CTRL_SLP_OK] & baseband_idle & ~host_need;
    assign host_need  = evt_ff | ctrl_ff[`BHP_CTRL_ATTN];

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    // address and data may come in either order; one write at a time
    assign s_axi_awready = ~aw_full_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_full_ff & ~bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign do_write      = aw_full_ff & w_full_ff & ~bvalid_ff;
    assign wdec          = bhp_dec(aw_addr_ff);
    assign ev_clr        = do_write & w_lane0_ff & (wdec == 3'h7)
                           & w_data_ff[`BHP_EV_PEND];

    // capture, commit and answer
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_ff <= 1'b0;
            aw_addr_ff <= {AW{1'b0}};
            w_full_ff  <= 1'b0;
            w_data_ff  <= 32'h00000000;
            w_lane0_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `BHP_RESP_OKAY;
            ctrl_ff    <= `BHP_CTRL_RST;
            pwrdn_ff   <= `BHP_PWRDN_RST;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_ff  <= 1'b1;
                w_data_ff  <= s_axi_wdata;
                w_lane0_ff <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_full_ff <= 1'b0;
                w_full_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                // unmapped offsets answer slave error and store nothing
                bresp_ff   <= wdec[2] ? `BHP_RESP_OKAY : `BHP_RESP_SLVERR;
                if (w_lane0_ff && wdec == 3'h4)
                    ctrl_ff <= w_data_ff[7:0];
                if (w_lane0_ff && wdec == 3'h5)
                    pwrdn_ff <= {3'h0, w_data_ff[4:0]};
            end
            else if (bvalid_ff && s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    assign rdec          = bhp_dec(s_axi_araddr);
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rdata_ff;
    assign status_word   = {24'h000000, pd_ff, clk_req_ff,
                            hwake_ff, wake_act, (state_ff == `BHP_ST_RUN)};

    // read data select; reserved bits other than ctrl bit 7, and unmapped words, read zero
    always @*
    begin
        case (rdec)
            3'h4:    rd_mux = {24'h000000, ctrl_ff};
            3'h5:    rd_mux = {24'h000000, pwrdn_ff};
            3'h6:    rd_mux = status_word;
            3'h7:    rd_mux = {31'h00000000, evt_ff};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // a read answers one edge after the address is taken
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= `BHP_RESP_OKAY;
            rdata_ff  <= 32'h00000000;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= rdec[2] ? `BHP_RESP_OKAY : `BHP_RESP_SLVERR;
            rdata_ff  <= rd_mux;
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // host event flag
    // ------------------------------------------------------------------
    // a new event in the clearing cycle wins, so none is lost
    always @(posedge aclk)
    begin
        if (!aresetn)
            evt_ff <= 1'b0;
        else
            evt_ff <= baseband_host_event | (evt_ff & ~ev_clr);
    end

    // ------------------------------------------------------------------
    // sleep state machine
    // ------------------------------------------------------------------
    // the wake line vetoes sleep only while the handshake is in use
    always @*
    begin
        case (state_ff)
            `BHP_ST_RUN:
            begin
                if (sleep_crit && !(hs_on && wake_act))
                    nxt_state = `BHP_ST_SLEEP;
                else
                    nxt_state = `BHP_ST_RUN;
            end
            `BHP_ST_SLEEP:
            begin
                if ((hs_on && wake_act) || !sleep_crit)
                    nxt_state = `BHP_ST_RUN;
                else
                    nxt_state = `BHP_ST_SLEEP;
            end
            default: nxt_state = `BHP_ST_RUN;
        endcase
    end

    // ------------------------------------------------------------------
    // rf power-down controls
    // ------------------------------------------------------------------
    // each section is off when asleep, forced by software, or idle under
    // automatic packet handling; pll is shared by tx and rx, pa by tx
    always @*
    begin
        nxt_pd = pwrdn_ff[3:0];
        if (nxt_state == `BHP_ST_SLEEP)
            nxt_pd = 4'hF;
        else if (pwrdn_ff[`BHP_PD_AUTO])
        begin
            nxt_pd[`BHP_PD_TX]  = nxt_pd[`BHP_PD_TX]  | ~baseband_tx_active;
            nxt_pd[`BHP_PD_RX]  = nxt_pd[`BHP_PD_RX]  | ~baseband_rx_active;
            nxt_pd[`BHP_PD_PLL] = nxt_pd[`BHP_PD_PLL]
                                  | ~(baseband_tx_active | baseband_rx_active);
            nxt_pd[`BHP_PD_PA]  = nxt_pd[`BHP_PD_PA]  | ~baseband_tx_active;
        end
    end

    // ------------------------------------------------------------------
    // state, pins and power-down registers
    // ------------------------------------------------------------------
    // reset holds clock request low and host wake deasserted
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff   <= `BHP_ST_RUN;
            hwake_ff   <= 1'b0;
            clk_req_ff <= 1'b0;
            pd_ff      <= 4'h0;
        end
        else
        begin
            state_ff   <= nxt_state;
            hwake_ff   <= hs_on & host_need;
            clk_req_ff <= (nxt_state == `BHP_ST_RUN)
                          | ctrl_ff[`BHP_CTRL_CLK_REQ]
                          | wlan_clk_need;
            pd_ff      <= nxt_pd;
        end
    end

    // host wake pin polarity follows software; reset level is active-high
    // deasserted until software sets both handshake enable and uart mode
    assign host_wake_from_radio = ~(hwake_ff ^ ctrl_ff[`BHP_CTRL_HWK_POL]);
    assign clk_req      = clk_req_ff;
    assign pd_tx        = pd_ff[`BHP_PD_TX];
    assign pd_rx        = pd_ff[`BHP_PD_RX];
    assign pd_pll       = pd_ff[`BHP_PD_PLL];
    assign pd_pa        = pd_ff[`BHP_PD_PA];
    assign radio_asleep = (state_ff == `BHP_ST_SLEEP);
endmodule // bhp_power_handshake

`default_nettype wire

// File: bhp_props.sv
`default_nettype none
// ----------------------------------------------------------------------
// checker on the top ports of the power handshake block
// ----------------------------------------------------------------------
module bhp_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        clk_req,
    input wire logic        wlan_clk_need,
    input wire logic        radio_asleep,
    input wire logic        pd_tx,
    input wire logic        pd_rx,
    input wire logic        pd_pll,
    input wire logic        pd_pa
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // read address taken, then data waits on the master
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_r_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence

    chk_read_lat: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read data late");
    chk_r_hold: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
    chk_b_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    // reset must be seen even though the others are disabled by it
    chk_rst_clk: assert property (disable iff (1'b0) !aresetn |=> !clk_req)
        else $error("clock request high in reset");
    chk_wlan_clk: assert property (wlan_clk_need |=> clk_req)
        else $error("clock request ignores wlan need");
    // past guard skips the first edge after release, where regs still hold reset
    chk_run_clk: assert property (!radio_asleep && $past(aresetn) |-> clk_req)
        else $error("clock request low while running");
    chk_sleep_pd: assert property (radio_asleep |-> pd_tx && pd_rx && pd_pll && pd_pa)
        else $error("rf section powered in sleep");
endmodule // bhp_props

bind bhp_power_handshake bhp_props u_props (.*);
`default_nettype wire

// File: bhp_sync.v
`default_nettype none

// ----------------------------------------------------------------------
// two-flop synchroniser for asynchronous levels
// ----------------------------------------------------------------------
module bhp_sync #(
    parameter WIDTH = 1
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_ff;   // first stage, read by second stage only
    reg [WIDTH-1:0] sync_ff;   // second stage, safe to use

    // both stages clear on reset to a known idle level
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // bhp_sync

`default_nettype wire

// File: bhp_tb.sv
`include "bhp_map.vh"
`default_nettype none
// ----------------------------------------------------------------------
// bench: register tasks plus pin checks
// ----------------------------------------------------------------------
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rv;
    logic [3:0]  wstrb;
    logic [1:0]  rr;
    logic        idle, hev, tx, rx, wlan, want, dpol, hpol;
    wire         awready, wready, bvalid, arready, rvalid;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire         wpin, hpin, clk_req, pd_tx, pd_rx, pd_pll, pd_pa, asleep, host_awake;
    wire [3:0]   pd = {pd_pa, pd_pll, pd_rx, pd_tx};
    int          err_total, num_checks;

    bhp_power_handshake #(.AW(8)) uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .radio_wake_from_host(wpin),
        .host_wake_from_radio(hpin), .clk_req(clk_req), .baseband_idle(idle),
        .baseband_host_event(hev), .baseband_tx_active(tx), .baseband_rx_active(rx),
        .wlan_clk_need(wlan), .pd_tx(pd_tx), .pd_rx(pd_rx), .pd_pll(pd_pll),
        .pd_pa(pd_pa), .radio_asleep(asleep));
    bhp_host_model u_host (.want_wake(want), .dev_pol_hi(dpol), .host_pol_hi(hpol),
        .host_wake_from_radio(hpin), .radio_wake_from_host(wpin), .host_awake(host_awake));

    // free-running 100 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ------------------------------------------------------------------
    // compare, wait and bus tasks
    // ------------------------------------------------------------------
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    task cb(input string n, input logic e, input logic g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask
    // edges then a mid-cycle sample point, so outputs have settled
    task w(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    // ready is read mid-cycle; inputs only move right after rising edges
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic da, dw, db;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        db = 1'b0;
        while (!db)
        begin
            @(negedge aclk);
            da = awvalid && awready;
            dw = wvalid && wready;
            db = bready && bvalid;
            rr = bresp;
            @(posedge aclk);
            if (da) awvalid <= 1'b0;
            if (dw) wvalid <= 1'b0;
            if (db) bready <= 1'b0;
        end
        chk("bresp", 32'h0, {30'h0, rr});
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic da, dr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        dr = 1'b0;
        while (!dr)
        begin
            @(negedge aclk);
            da = arvalid && arready;
            dr = rready && rvalid;
            rv = rdata;
            rr = rresp;
            @(posedge aclk);
            if (da) arvalid <= 1'b0;
            if (dr) rready <= 1'b0;
        end
        chk("rdata", e, rv);
        chk("rresp", {30'h0, er}, {30'h0, rr});
    endtask
    task done(input string n);
        $display("test %s finished", n);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // watchdog: the whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge aclk);
        err_total++;
        wrap_up;
    end

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hF};
        {idle, hev, tx, rx, wlan, want, dpol, hpol} = 8'h03;
        err_total = 0;
        num_checks = 0;
        w(4);
        cb("clk_req", 1'b0, clk_req);
        chk("pd", 32'h0, {28'h0, pd});
        @(posedge aclk);
        aresetn <= 1'b1;
        w(1);
        cb("clk_req", 1'b1, clk_req);
        rc(`BHP_OFF_CTRL, 32'h0000000C, 2'h0);
        rc(`BHP_OFF_PWRDN, 32'h00000010, 2'h0);
        rc(8'h10, 32'h0, 2'h2);
        done("reset");
        // sleep on idle baseband, then clock request by wlan and wake by host
        wr(`BHP_OFF_CTRL, 32'h0000001F);
        @(posedge aclk);
        idle <= 1'b1;
        w(3);
        cb("asleep", 1'b1, asleep);
        chk("pd", 32'hF, {28'h0, pd});
        cb("clk_req", 1'b0, clk_req);
        // software clock request holds the line up while asleep
        wr(`BHP_OFF_CTRL, 32'h0000005F);
        w(1);
        cb("clk_req", 1'b1, clk_req);
        wr(`BHP_OFF_CTRL, 32'h0000001F);
        w(1);
        cb("clk_req", 1'b0, clk_req);
        @(posedge aclk);
        wlan <= 1'b1;
        w(2);
        cb("clk_req", 1'b1, clk_req);
        @(posedge aclk);
        wlan <= 1'b0;
        want <= 1'b1;
        w(4);
        cb("asleep", 1'b0, asleep);
        rc(`BHP_OFF_STATUS, 32'h000000FB, 2'h0);
        done("sleep_wake");
        // active-low device wake, then handshake off outside uart mode
        wr(`BHP_OFF_CTRL, 32'h0000001B);
        @(posedge aclk);
        dpol <= 1'b0;
        w(4);
        cb("asleep", 1'b0, asleep);
        @(posedge aclk);
        want <= 1'b0;
        w(4);
        cb("asleep", 1'b1, asleep);
        wr(`BHP_OFF_CTRL, 32'h0000001D);
        @(posedge aclk);
        dpol <= 1'b1;
        want <= 1'b1;
        w(4);
        cb("asleep", 1'b1, asleep);
        @(posedge aclk);
        want <= 1'b0;
        idle <= 1'b0;
        w(2);
        cb("asleep", 1'b0, asleep);
        done("polarity");
        // host wake from a baseband event, cleared by software
        wr(`BHP_OFF_CTRL, 32'h0000000F);
        @(posedge aclk);
        hev <= 1'b1;
        @(posedge aclk);
        hev <= 1'b0;
        w(2);
        cb("host_awake", 1'b1, host_awake);
        rc(`BHP_OFF_EVENT, 32'h1, 2'h0);
        wr(`BHP_OFF_EVENT, 32'h1);
        w(2);
        cb("host_awake", 1'b0, host_awake);
        @(posedge aclk);
        hpol <= 1'b0;
        wr(`BHP_OFF_CTRL, 32'h00000007);
        w(1);
        cb("host_wake", 1'b1, hpin);
        // software attention request raises host wake, active low now
        wr(`BHP_OFF_CTRL, 32'h00000027);
        w(1);
        cb("host_awake", 1'b1, host_awake);
        done("host_wake");
        // packet driven and forced power-downs
        @(posedge aclk);
        tx <= 1'b1;
        w(2);
        chk("pd", 32'h2, {28'h0, pd});
        wr(`BHP_OFF_PWRDN, 32'h11);
        w(2);
        chk("pd", 32'h3, {28'h0, pd});
        wr(`BHP_OFF_PWRDN, 32'h0);
        w(2);
        chk("pd", 32'h0, {28'h0, pd});
        done("power_down");
        // reset in mid-run drops the clock request until release
        @(posedge aclk);
        aresetn <= 1'b0;
        w(2);
        cb("clk_req", 1'b0, clk_req);
        @(posedge aclk);
        aresetn <= 1'b1;
        w(1);
        cb("clk_req", 1'b1, clk_req);
        done("reset_again");
        wrap_up;
    end
endmodule // tb
`default_nettype wire
